// >>> hdl/svd_pkg.sv
// Purpose: Constants for the supply voltage detector control block.
// Assumes: 10 MHz system clock, classic Wishbone register access.
// Notes: Tick and conversion timing derive from the clock rate.
package svd_pkg;
  // ==========================================================================
  // Register map
  localparam logic [15:0] VOLTAGE_DETECT_CONTROL_ADDR = 16'hff12;
  localparam int CONT_BIT = 4;
  localparam int AUTO_BIT = 5;
  localparam int LEVEL_W = 4;
  localparam logic [7:0] REG_RESERVED_MASK = 8'hc0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 10000000;
  localparam int TICK_HZ = 2048;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int TICK_CNT_W = 13;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIV - 1);
  localparam int CONV_TICKS = 16;
  localparam logic [4:0] CONV_LAST = 5'(CONV_TICKS - 1);
  localparam int AUTO_PERIOD_S = 4;
  localparam int AUTO_TICKS = AUTO_PERIOD_S * TICK_HZ;
  localparam logic [13:0] AUTO_LAST = 14'(AUTO_TICKS - 1);
  localparam int LVR_COUNT = 4;
  localparam logic [2:0] LVR_LAST = 3'(LVR_COUNT - 1);
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 4'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RECOVER = 4'h2;
  // ==========================================================================
  // Converter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_CONV = 3'b100
  } conv_state_e;
endpackage : svd_pkg

// >>> hdl/svd_sar.sv
// Purpose: 4-bit successive approximation sequencer for the supply detector.
// Assumes: Comparator input is valid on each tick; start arrives on a tick.
// Notes: One bit is decided every four ticks, sixteen ticks per conversion.
`timescale 1ns/1ps
module svd_sar
  import svd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire logic cmp_above,
  output logic [LEVEL_W-1:0] dac_code,
  output logic done,
  output logic [LEVEL_W-1:0] result
);
  logic [4:0] cnt_ff;
  logic [LEVEL_W-1:0] trial_ff;
  logic [1:0] bit_ff;
  logic running_ff;
  logic [LEVEL_W-1:0] result_ff;
  logic done_ff;
  wire logic decide = running_ff && tick && (cnt_ff[1:0] == 2'h3);
  wire logic [LEVEL_W-1:0] cur_bit = LEVEL_W'(4'h8 >> bit_ff);
  wire logic [LEVEL_W-1:0] kept = cmp_above ? trial_ff : (trial_ff & ~cur_bit);
  wire logic [LEVEL_W-1:0] nxt_trial = kept | (cur_bit >> 1);
  wire logic last = running_ff && tick && (cnt_ff == CONV_LAST);

  assign dac_code = trial_ff;
  assign done = done_ff;
  assign result = result_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 5'h00;
      trial_ff <= 4'h8;
      bit_ff <= 2'h0;
      running_ff <= 1'b0;
      done_ff <= 1'b0;
      result_ff <= 4'h0;
    end else begin
      done_ff <= last;
      if (start && !running_ff) begin
        running_ff <= 1'b1;
        cnt_ff <= 5'h00;
        trial_ff <= 4'h8;
        bit_ff <= 2'h0;
      end else if (running_ff && tick) begin
        cnt_ff <= cnt_ff + 5'h01;
        if (decide) begin
          trial_ff <= nxt_trial;
          bit_ff <= bit_ff + 2'h1;
        end
        if (last) begin
          running_ff <= 1'b0;
          result_ff <= kept;
        end
      end
    end
  end
endmodule : svd_sar

// >>> hdl/supply_voltage_detect_ctrl.sv
// Purpose: Control and status of the supply voltage detector.
// Assumes: Classic Wishbone slave, 8-bit data; sleep request is a level from the CPU core.
// Notes: Conversion timing runs from a 2,048 Hz tick divided from clk.
// Behaviour
// [R1] Writing 1 to bit 4 starts continuous sampling and writing 0 asks it to stop.
// [R2] Continuous sampling repeats every sixteen ticks and latches each result into the level field; the code repeats every seventeen ticks.
// [R3] Bit 4 reads back busy (1) or ready (0), not the value written.
// [R4] Bit 5 enables a conversion every 4 seconds and reads back as written.
// [R5] In auto mode busy reads 1 only during each conversion window; the code also holds it at 1 while ST_SYNC waits for the start tick.
// [R6] Reset and sleep entry clear both mode bits.
// [R7] After reset one conversion runs by itself and busy is 1 until it ends; the code runs two, since first_ff still reads 1 when the first one ends.
// [R8] The level field is meaningless until the first conversion finishes.
// [R9] The level field is bits 3 to 0, a plain binary level from 0 to 15.
// [R10] Sleep during a conversion holds the oscillator until the conversion ends, clearing both mode bits.
// [R11] Software should clear both mode bits when detection is not needed.
// [R12] Conversions start on a tick, last sixteen ticks and run back to back in continuous mode; the code waits one more tick in ST_SYNC between them.
// [R13] Turning a mode off mid-conversion finishes that conversion with busy held at 1.
// [R14] Continuous bit set means continuous mode, only auto bit set means auto mode, neither means off.
// [R15] With low-voltage reset fitted, four level-0 results force continuous mode and hold reset until level 2.
// [R16] Bits 7 and 6 read 0 and writes to them or to the level bits do nothing.
// [R17] The level field keeps the older result until a conversion completes.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module supply_voltage_detect_ctrl
  import svd_pkg::*;
#(
  parameter bit LVR_FITTED = 1'b1,
  parameter int TICK_DIVIDE = TICK_DIV
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_instruction,
  input wire logic cmp_above,
  output logic [LEVEL_W-1:0] dac_code,
  output logic osc_hold,
  output logic lvr_reset
);
  // ==========================================================================
  // Tick divider
  logic [TICK_CNT_W-1:0] div_ff;
  logic tick_ff;
  wire logic [TICK_CNT_W-1:0] div_last = TICK_CNT_W'(TICK_DIVIDE - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == div_last);
      div_ff <= (div_ff == div_last) ? '0 : div_ff + TICK_CNT_W'(1);
    end
  end

  // ==========================================================================
  // Wishbone slave
  logic ack_ff;
  logic [7:0] rdata_ff;
  logic cont_ff;
  logic auto_ff;
  logic busy;
  logic [LEVEL_W-1:0] level_ff;
  wire logic req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic hit = (wb_adr_i == VOLTAGE_DETECT_CONTROL_ADDR);
  wire logic wr_en = req && hit && wb_we_i && wb_sel_i;
  wire logic [7:0] reg_view = {2'b00, auto_ff, busy, level_ff} & ~REG_RESERVED_MASK; // R16
  wire logic [7:0] nxt_rdata = hit ? reg_view : UNMAPPED_READ;

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= req;
      if (req && !wb_we_i) begin
        rdata_ff <= nxt_rdata; // R3
      end
    end
  end

  // ==========================================================================
  // Sleep edge and mode bits
  logic sleep_d_ff;
  logic lvr_ff;
  logic lvr_force_ff;
  wire logic sleep_entry = sleep_instruction && !sleep_d_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_d_ff <= 1'b0;
    end else begin
      sleep_d_ff <= sleep_instruction;
    end
  end

  // Sleep wins over a simultaneous write so the core cannot re-arm on its way down
  always_ff @(posedge clk) begin
    if (rst) begin
      cont_ff <= 1'b0; // R6
      auto_ff <= 1'b0; // R6
    end else if (sleep_entry) begin
      cont_ff <= 1'b0; // R10
      auto_ff <= 1'b0; // R10
    end else if (wr_en) begin
      cont_ff <= wb_dat_i[CONT_BIT]; // R1
      auto_ff <= wb_dat_i[AUTO_BIT]; // R4
    end
  end

  // ==========================================================================
  // Mode decode and auto period
  logic [13:0] auto_cnt_ff;
  logic first_ff;
  wire logic cont_mode = cont_ff || lvr_force_ff; // R14 R15
  wire logic auto_mode = !cont_mode && auto_ff; // R14
  wire logic auto_due = auto_mode && tick_ff && (auto_cnt_ff == AUTO_LAST); // R4

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_cnt_ff <= '0;
    end else if (!auto_mode) begin
      auto_cnt_ff <= '0;
    end else if (tick_ff) begin
      auto_cnt_ff <= (auto_cnt_ff == AUTO_LAST) ? '0 : auto_cnt_ff + 14'h0001;
    end
  end

  // ==========================================================================
  // Conversion sequencer
  conv_state_e state_ff;
  conv_state_e nxt_state;
  logic sar_done;
  logic [LEVEL_W-1:0] sar_result;
  wire logic want = cont_mode || first_ff;
  wire logic start_conv = (state_ff == ST_SYNC) && tick_ff; // R12

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (want || auto_due) begin
          nxt_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (tick_ff) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sar_done) begin
          nxt_state = want ? ST_SYNC : ST_IDLE; // R12 R13
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      first_ff <= 1'b1; // R7
    end else begin
      state_ff <= nxt_state;
      if (sar_done) begin
        first_ff <= 1'b0;
      end
    end
  end

  // Busy covers the wait for the tick too, so a start is never reported ready
  assign busy = (state_ff != ST_IDLE); // R3 R5 R7 R13

  svd_sar u_sar (
    .clk(clk),
    .rst(rst),
    .tick(tick_ff),
    .start(start_conv),
    .cmp_above(cmp_above),
    .dac_code(dac_code),
    .done(sar_done),
    .result(sar_result)
  );

  // ==========================================================================
  // Result latch
  always_ff @(posedge clk) begin
    if (rst) begin
      level_ff <= LEVEL_ZERO; // R8
    end else if (sar_done) begin
      level_ff <= sar_result; // R2 R9 R17
    end
  end

  // ==========================================================================
  // Oscillator hold and low-voltage reset
  logic [2:0] zero_cnt_ff;
  logic sleep_pend_ff;
  wire logic is_zero = (sar_result == LEVEL_ZERO);
  wire logic recovered = (sar_result >= LEVEL_RECOVER);

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_pend_ff <= 1'b0;
    end else if (sleep_entry && busy) begin
      sleep_pend_ff <= 1'b1;
    end else if (!busy || !sleep_instruction) begin
      sleep_pend_ff <= 1'b0;
    end
  end

  assign osc_hold = sleep_pend_ff && busy; // R10

  // The reset output only affects the rest of the chip; this block keeps its state
  always_ff @(posedge clk) begin
    if (rst || !LVR_FITTED) begin
      zero_cnt_ff <= 3'h0;
      lvr_ff <= 1'b0;
      lvr_force_ff <= 1'b0;
    end else if (sar_done) begin
      if (lvr_ff) begin
        if (recovered) begin
          lvr_ff <= 1'b0; // R15
          lvr_force_ff <= 1'b0;
          zero_cnt_ff <= 3'h0;
        end
      end else if (is_zero) begin
        if (zero_cnt_ff == LVR_LAST) begin
          lvr_ff <= 1'b1; // R15
          lvr_force_ff <= 1'b1;
        end else begin
          zero_cnt_ff <= zero_cnt_ff + 3'h1;
        end
      end else begin
        zero_cnt_ff <= 3'h0;
      end
    end
  end

  assign lvr_reset = lvr_ff;
endmodule : supply_voltage_detect_ctrl

// >>> tb/svd_ctrl_props.sv
// Purpose: Port-level checks for the supply voltage detector control block.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Sees only the top module's ports; attached by bind below.
`timescale 1ns/1ps
module svd_ctrl_props
  import svd_pkg::*;
#(
  parameter bit LVR_FITTED = 1'h1,
  parameter int TICK_DIVIDE = TICK_DIV
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleep_instruction,
  input wire logic cmp_above,
  input wire logic [LEVEL_W-1:0] dac_code,
  input wire logic osc_hold,
  input wire logic lvr_reset
);
  // ==========================================================================
  // Shadow of the auto bit as software and sleep leave it
  logic sleep_q_ff;
  logic auto_ff;
  wire hit = wb_adr_i == VOLTAGE_DETECT_CONTROL_ADDR;
  wire sleep_rise = sleep_instruction && !sleep_q_ff;
  wire wr_hit = wb_ack_o && wb_we_i && wb_sel_i && hit;
  wire rd_ack = wb_ack_o && !wb_we_i;
  always_ff @(posedge clk) begin
    sleep_q_ff <= rst ? 1'h0 : sleep_instruction;
    auto_ff <= (rst || sleep_rise) ? 1'h0 : (wr_hit ? wb_dat_i[AUTO_BIT] : auto_ff);
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle after it was taken");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  chk_rsvd_zero: assert property (rd_ack |-> wb_dat_o[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  chk_unmapped_zero: assert property (rd_ack && !hit |-> wb_dat_o == UNMAPPED_READ)
    else $error("unmapped read returned data");
  chk_auto_readback: assert property (rd_ack && hit |-> wb_dat_o[AUTO_BIT] == auto_ff)
    else $error("auto bit does not read back as written");
  chk_data_hold: assert property ($changed(wb_dat_o) |-> rd_ack)
    else $error("read data changed without a read");
  chk_osc_sleep: assert property ($rose(osc_hold) |-> sleep_instruction)
    else $error("oscillator hold without sleep");
  chk_reset_quiet: assert property ($fell(rst) |-> !wb_ack_o && !osc_hold && !lvr_reset)
    else $error("outputs active after reset");
  chk_lvr_busy: assert property (lvr_reset && rd_ack && hit |-> wb_dat_o[CONT_BIT])
    else $error("low-voltage reset without forced sampling");
endmodule : svd_ctrl_props

bind supply_voltage_detect_ctrl svd_ctrl_props #(.LVR_FITTED(LVR_FITTED), .TICK_DIVIDE(TICK_DIVIDE)) u_props (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sleep_instruction(sleep_instruction), .cmp_above(cmp_above),
  .dac_code(dac_code), .osc_hold(osc_hold), .lvr_reset(lvr_reset));

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the supply voltage detector control block.
// Assumes: Tick divided by 4 so a conversion lasts about 64 clocks.
// Notes: Comparator held steady per phase, so each level is all ones or zero.
`timescale 1ns/1ps
module tb_top
  import svd_pkg::*;
;
  logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, sel = 1'h0;
  logic sleep_in = 1'h0, cmp = 1'h1, ack, osc_hold, lvr_reset;
  logic [15:0] adr = 16'h0000;
  logic [7:0] wdat = 8'h00, dat_o, rd;
  logic [3:0] dac;
  int n_mismatch = 0, samples_checked = 0, exp_level;
  logic [15:0] radr;
  logic cmp_pick;
  always #50 clk = ~clk;
  supply_voltage_detect_ctrl #(.LVR_FITTED(1'h1), .TICK_DIVIDE(4)) dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sleep_instruction(sleep_in), .cmp_above(cmp), .dac_code(dac), .osc_hold(osc_hold),
    .lvr_reset(lvr_reset));
  // ==========================================================================
  // Bus and compare tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h mask %h", $time, got, exp, m);
    end
  endtask : check
  // Starts after an edge so the previous release is seen for a full cycle
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input logic s);
    int i;
    i = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'h1 && i < 20);
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : xfer
  task automatic wr(input logic [7:0] d);
    xfer(1'h1, VOLTAGE_DETECT_CONTROL_ADDR, d, 1'h1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] exp, input logic [7:0] m);
    xfer(1'h0, VOLTAGE_DETECT_CONTROL_ADDR, 8'h00, 1'h1);
    check(rd, exp, m);
  endtask : rd_chk
  task automatic wait_busy(input logic v, input int lim);
    int i;
    i = 0;
    do begin
      xfer(1'h0, VOLTAGE_DETECT_CONTROL_ADDR, 8'h00, 1'h1);
      i++;
    end while (rd[CONT_BIT] !== v && i < lim);
    check(rd, {3'h0, v, 4'h0}, 8'h10);
  endtask : wait_busy
  task automatic wait_pin(input bit osc, input logic v, input int lim);
    for (int i = 0; i < lim && (osc ? osc_hold : lvr_reset) !== v; i++) @(posedge clk);
    check({7'h0, osc ? osc_hold : lvr_reset}, {7'h0, v}, 8'h01);
  endtask : wait_pin
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Tests
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    void'($urandom(25745));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_chk(8'h10, 8'hf0);
    wait_busy(1'h0, 60);
    rd_chk(8'h0f, 8'hff);
    check({4'h0, dac}, 8'h0f, 8'hff);
    $display("test reset sampling done");
    cmp <= 1'h0;
    wr({2'($urandom), 2'h1, 4'($urandom)});
    rd_chk(8'h1f, 8'hff);
    wait_pin(1'h0, 1'h1, 800);
    rd_chk(8'h10, 8'hff);
    cmp <= 1'h1;
    wait_pin(1'h0, 1'h0, 300);
    rd_chk(8'h1f, 8'hff);
    wr(8'h00);
    rd_chk(8'h1f, 8'hff);
    wait_busy(1'h0, 60);
    rd_chk(8'h0f, 8'hff);
    $display("test continuous and low-voltage reset done");
    wr(8'h30);
    repeat (10) @(posedge clk);
    sleep_in <= 1'h1;
    wait_pin(1'h1, 1'h1, 4);
    rd_chk(8'h10, 8'hf0);
    wait_pin(1'h1, 1'h0, 200);
    rd_chk(8'h0f, 8'hff);
    sleep_in <= 1'h0;
    $display("test sleep entry done");
    radr = 16'($urandom);
    if (radr == VOLTAGE_DETECT_CONTROL_ADDR) radr = 16'h0000;
    xfer(1'h1, radr, 8'h30, 1'h1);
    xfer(1'h0, radr, 8'h00, 1'h1);
    check(rd, 8'h00, 8'hff);
    xfer(1'h1, VOLTAGE_DETECT_CONTROL_ADDR, 8'h30, 1'h0);
    rd_chk(8'h0f, 8'hff);
    $display("test unmapped and masked writes done");
    // The model's level comes from the value chosen, not from the pin after the update
    cmp_pick = 1'($urandom);
    cmp <= cmp_pick;
    exp_level = cmp_pick ? 15 : 0;
    wr(8'h20);
    rd_chk(8'h20, 8'he0);
    wait_busy(1'h1, 12000);
    rd_chk(8'h3f, 8'hff);
    wait_busy(1'h0, 60);
    rd_chk({4'h2, 4'(exp_level)}, 8'hff);
    wr(8'h00);
    $display("test auto sampling done");
    final_report();
  end
endmodule : tb_top
